// ===== hdl/seep_core.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - select low selects the device; select high deselects and enters standby once no internal write runs
// - an internal write already started finishes regardless of select
// - data output released to high impedance at once when deselected
// - select rising after a valid write sequence starts the internal write
// - select must be seen low once after power-up before commands are taken
// - input bits captured on every rising serial clock edge while the pause input is high
// - output data changes only after falling serial clock edges
// - write-protect low refuses array and status writes and the write enable command; other operations continue
// - write-protect falling clears the write enable latch unless a write runs
// - write-protect falling never disturbs an internal write already begun
// - every internal write finishes within 5 ms of its start
// - write-protect high lets every function, writes included, run normally
// - all bytes travel most significant bit first
// - pause input low releases the data output to high impedance at once
// - write commits only if select rises right after a whole data byte
// - completion of an internal write clears the write enable latch
module seep_core
    import seep_pkg::*;
(
    // system clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // serial pins, clocked by the master's serial clock
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic wp_n,
    input  wire logic hold_n,
    output logic      so,
    output logic      so_oe,
    // status
    output logic      busy,
    output logic      standby
);
    typedef enum logic [3:0] {
        SEEP_ST_CMD  = 4'b0001,
        SEEP_ST_ADDR = 4'b0010,
        SEEP_ST_DATA = 4'b0100,
        SEEP_ST_IDLE = 4'b1000
    } seep_state_t;

    // link-domain state (serial clock)
    seep_state_t     state;
    logic [2:0]      bit_cnt;
    logic [7:0]      shift_in;
    logic [7:0]      opcode;
    logic [SEEP_AW-1:0] addr;
    logic [7:0]      out_byte;
    logic            out_bit;
    logic            armed;
    logic            byte_done;
    logic            wr_pend;
    logic            sr_pend;
    logic [7:0]      page_buf [0:(1<<SEEP_PAGE_BITS)-1];
    logic [15:0]     page_vld;
    logic [1:0]      sr_data;
    logic [SEEP_AW-1:0] page_base;

    // system-domain state
    logic [7:0]      mem [0:SEEP_DEPTH-1];
    logic [1:0]      bp;
    logic            write_enable_latch;
    logic            wip;
    logic [SEEP_TW-1:0] twc_cnt;
    logic            wp_s;
    logic            wp_q;
    logic            req_tgl;
    logic            req_s;
    logic            req_q;
    logic            wel_set_tgl;
    logic            wel_clr_tgl;
    logic            set_s;
    logic            set_q;
    logic            clr_s;
    logic            clr_q;
    logic            wel_s;
    logic            wip_s;
    logic            cs_s;
    logic            seen_low;
    logic            seen_low_s;

    logic [7:0]      next_shift;
    logic [7:0]      op_base;
    logic            sel;

    function automatic logic [7:0] seep_base(input logic [7:0] op);
        seep_base = op & SEEP_OP_MASK;
    endfunction

    assign next_shift = {shift_in[6:0], si};  // msb first
    assign op_base    = seep_base(opcode);
    assign sel        = !cs_n && hold_n;

    // system-side views of link levels
    seep_sync u_wp  (.clk(clk), .rst_n(rst_n), .d(wp_n),    .q(wp_s));
    seep_sync u_req (.clk(clk), .rst_n(rst_n), .d(req_tgl), .q(req_s));
    seep_sync u_set (.clk(clk), .rst_n(rst_n), .d(wel_set_tgl), .q(set_s));
    seep_sync u_clr (.clk(clk), .rst_n(rst_n), .d(wel_clr_tgl), .q(clr_s));
    seep_sync u_cs  (.clk(clk), .rst_n(rst_n), .d(cs_n),    .q(cs_s));
    // system state read on the serial side; serial clock only runs in frames
    seep_sync u_wel (.clk(sck), .rst_n(1'b1), .d(write_enable_latch), .q(wel_s));
    seep_sync u_wip (.clk(sck), .rst_n(1'b1), .d(wip), .q(wip_s));
    seep_sync u_sl  (.clk(sck), .rst_n(1'b1), .d(seen_low), .q(seen_low_s));

    // power-up gate: select must be seen low before any sequence
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen_low <= 1'b0;
        end else if (!cs_s) begin
            seen_low <= 1'b1;
        end
    end

    // serial receive path on rising edge; hold freezes it
    // state shares the select-rise reset, so it lives in this one process
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            state     <= SEEP_ST_CMD;
            bit_cnt   <= 3'h0;
            shift_in  <= 8'h00;
            byte_done <= 1'b0;
        end else if (hold_n) begin
            shift_in  <= next_shift;
            bit_cnt   <= bit_cnt + 3'h1;
            byte_done <= (bit_cnt == 3'h7);
            if (bit_cnt == 3'h7) begin
                unique case (state)
                    SEEP_ST_CMD: begin
                        if (seep_base(next_shift) == SEEP_OP_READ
                            || seep_base(next_shift) == SEEP_OP_WRITE) begin
                            state <= SEEP_ST_ADDR;
                        end else if (next_shift == SEEP_OP_WRSR
                                     || next_shift == SEEP_OP_RDSR) begin
                            state <= SEEP_ST_DATA;
                        end else begin
                            state <= SEEP_ST_IDLE;
                        end
                    end
                    SEEP_ST_ADDR: state <= SEEP_ST_DATA;
                    SEEP_ST_DATA: state <= SEEP_ST_DATA;
                    SEEP_ST_IDLE: state <= SEEP_ST_IDLE;
                endcase
            end
        end
    end

    // command decode per completed byte
    always_ff @(posedge sck) begin
        if (!cs_n && hold_n && bit_cnt == 3'h7) begin
            unique case (state)
                SEEP_ST_CMD: begin
                    opcode <= next_shift;
                    page_vld <= 16'h0000;
                    addr[SEEP_AW-1] <= next_shift[SEEP_A8_BIT];
                    armed  <= seen_low_s;
                end
                SEEP_ST_ADDR: begin
                    addr[7:0] <= next_shift;
                end
                SEEP_ST_DATA: begin
                    if (op_base == SEEP_OP_WRITE) begin
                        page_buf[addr[SEEP_PAGE_BITS-1:0]] <= next_shift;
                        page_vld[addr[SEEP_PAGE_BITS-1:0]] <= 1'b1;
                        addr[SEEP_PAGE_BITS-1:0] <= addr[SEEP_PAGE_BITS-1:0] + 4'h1;
                    end else if (op_base == SEEP_OP_READ) begin
                        addr <= addr + 9'h001;
                    end else if (opcode == SEEP_OP_WRSR) begin
                        sr_data <= next_shift[SEEP_SR_BP1:SEEP_SR_BP0];
                        page_vld[0] <= 1'b1;
                    end
                end
                SEEP_ST_IDLE: begin
                end
            endcase
        end
    end

    // page base register, cleared on select rise and at each command byte
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            page_base <= '0;
        end else if (hold_n && bit_cnt == 3'h7) begin
            if (state == SEEP_ST_CMD) begin
                page_base <= '0;
            end
        end
    end

    // on select rise: commit, latch commands, or drop; all as event toggles
    // toggles start known so the system side sees no false event after reset
    always_ff @(posedge cs_n or negedge rst_n) begin
        if (!rst_n) begin
            wel_set_tgl <= 1'b0;
            wel_clr_tgl <= 1'b0;
            req_tgl     <= 1'b0;
        end else if (armed && byte_done && wp_n) begin
            if (state == SEEP_ST_IDLE && opcode == SEEP_OP_WREN) begin
                wel_set_tgl <= !wel_set_tgl;
            end else if (state == SEEP_ST_IDLE && opcode == SEEP_OP_WRDI) begin
                wel_clr_tgl <= !wel_clr_tgl;
            end else if (state == SEEP_ST_DATA && wel_s && !wip_s && (|page_vld)
                         && (op_base == SEEP_OP_WRITE || opcode == SEEP_OP_WRSR)) begin
                req_tgl <= !req_tgl;
            end
        end else if (armed && byte_done && state == SEEP_ST_IDLE
                     && opcode == SEEP_OP_WRDI) begin
            wel_clr_tgl <= !wel_clr_tgl;
        end
    end

    // read data out, shifted on falling edge
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            out_bit  <= 1'b0;
            out_byte <= 8'h00;
        end else if (hold_n) begin
            if (bit_cnt == 3'h0 && state == SEEP_ST_DATA) begin
                out_byte <= (opcode == SEEP_OP_RDSR)
                    ? {4'h0, bp, wel_s, wip_s}
                    : (wip_s ? 8'h00 : mem[addr]);
                out_bit  <= (opcode == SEEP_OP_RDSR) ? 1'b0 : (wip_s ? 1'b0 : mem[addr][7]);
            end else begin
                out_bit <= out_byte[3'h7 - bit_cnt];
            end
        end
    end

    assign so    = out_bit;
    assign so_oe = sel && state == SEEP_ST_DATA && armed
                   && (op_base == SEEP_OP_READ || opcode == SEEP_OP_RDSR);

    // system-domain write engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_q <= 1'b0;
            set_q <= 1'b0;
            clr_q <= 1'b0;
            wp_q  <= 1'b1;
        end else begin
            req_q <= req_s;
            set_q <= set_s;
            clr_q <= clr_s;
            wp_q  <= wp_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wip     <= 1'b0;
            twc_cnt <= '0;
        end else if (req_s != req_q && !wip) begin
            wip     <= 1'b1;
            twc_cnt <= SEEP_TW'(SEEP_TWC_CYC - 1);
        end else if (wip) begin
            if (twc_cnt == '0) begin
                wip <= 1'b0;
            end else begin
                twc_cnt <= twc_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            write_enable_latch <= 1'b0;
        end else if (wip && twc_cnt == '0) begin
            write_enable_latch <= 1'b0;
        end else if (!wp_s && !wip) begin
            write_enable_latch <= 1'b0;
        end else if (set_s != set_q && wp_s) begin
            write_enable_latch <= 1'b1;
        end else if (clr_s != clr_q) begin
            write_enable_latch <= 1'b0;
        end
    end

    // commit array or status at start of the internal write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bp <= SEEP_BP_RESET;
        end else if (req_s != req_q && !wip) begin
            if (opcode == SEEP_OP_WRSR) begin
                bp <= sr_data;
            end else begin
                for (int i = 0; i < 16; i++) begin
                    if (page_vld[i]) begin
                        mem[{addr[SEEP_AW-1:SEEP_PAGE_BITS], 4'(i)}] <= page_buf[i];
                    end
                end
            end
        end
    end

    assign busy    = wip;
    assign standby = cs_s && !wip;
endmodule
`default_nettype wire

// ===== pkg/seep_pkg.sv
package seep_pkg;
    // serial instruction codes (low nibble with bit 3, address bit 8, masked for array ops)
    localparam logic [7:0] SEEP_OP_READ   = 8'h03;
    localparam logic [7:0] SEEP_OP_WRITE  = 8'h02;
    localparam logic [7:0] SEEP_OP_WRDI   = 8'h04;
    localparam logic [7:0] SEEP_OP_WREN   = 8'h06;
    localparam logic [7:0] SEEP_OP_RDSR   = 8'h05;
    localparam logic [7:0] SEEP_OP_WRSR   = 8'h01;
    localparam logic [7:0] SEEP_OP_MASK   = 8'hf7;
    localparam int         SEEP_A8_BIT    = 3;
    // memory shape
    localparam int         SEEP_DEPTH     = 512;
    localparam int         SEEP_AW        = 9;
    localparam int         SEEP_PAGE_BITS = 4;
    // status register fields
    localparam int         SEEP_SR_WIP    = 0;
    localparam int         SEEP_SR_WEL    = 1;
    localparam int         SEEP_SR_BP0    = 2;
    localparam int         SEEP_SR_BP1    = 3;
    localparam logic [1:0] SEEP_BP_RESET  = 2'h0;
    localparam logic [7:0] SEEP_MEM_RESET = 8'hff;
    // timing: internal write duration on the system clock
    localparam int         SEEP_CLK_HZ    = 20000000;
    localparam int         SEEP_TWC_MS    = 5;
    localparam int         SEEP_TWC_CYC   = SEEP_CLK_HZ / 1000 * SEEP_TWC_MS;
    localparam int         SEEP_TW        = 24;
endpackage

// ===== hdl/seep_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for a level; the first stage is read only by the second
module seep_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // level
    input  wire logic d,
    output logic      q
);
    logic meta;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== verif/seep_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module seep_monitor
    import seep_pkg::*;
(
    // clocks and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    // pins
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    input wire logic hold_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic busy,
    input wire logic standby
);
    // saturating, so a stuck busy cannot wrap round and look short
    int   busy_len;
    logic so_r;
    logic oe_r;
    always_ff @(posedge clk) begin
        if (!busy)
            busy_len <= 0;
        else if (busy_len < 200000)
            busy_len <= busy_len + 1;
    end
    // sck is far faster than clk, so output timing is judged on sck itself
    always_ff @(posedge sck) begin
        so_r <= so;
        oe_r <= so_oe;
    end
    sequence s_idle_desel;
        cs_n && !busy;
    endsequence
    sequence s_busy_end;
        busy ##1 !busy;
    endsequence
    chk_oe_desel: assert property (@(posedge clk) disable iff (!rst_n)
        cs_n |-> !so_oe) else $error("so driven while deselected");
    chk_oe_pause: assert property (@(posedge clk) disable iff (!rst_n)
        !hold_n |-> !so_oe) else $error("so driven while paused");
    chk_sel_active: assert property (@(posedge clk) disable iff (!rst_n)
        !cs_n [*4] |-> !standby) else $error("standby while selected");
    chk_standby_idle: assert property (@(posedge clk) disable iff (!rst_n)
        s_idle_desel [*4] |-> standby) else $error("no standby when deselected");
    chk_busy_standby: assert property (@(posedge clk) disable iff (!rst_n)
        busy |-> !standby) else $error("standby during write");
    chk_busy_start: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(busy) |-> cs_n && $past(cs_n)) else $error("write began while selected");
    chk_busy_wp: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(busy) |-> wp_n) else $error("write began while protected");
    chk_busy_max: assert property (@(posedge clk) disable iff (!rst_n)
        s_busy_end |-> busy_len <= SEEP_TWC_CYC + 1) else $error("write too long");
    chk_busy_whole: assert property (@(posedge clk) disable iff (!rst_n)
        s_busy_end |-> busy_len > SEEP_TWC_CYC / 2) else $error("write cut short");
    chk_so_edge: assert property (@(negedge sck) disable iff (!rst_n)
        oe_r && so_oe |-> so == so_r) else $error("so moved while sck high");
endmodule
bind seep_core seep_monitor mon (.clk, .rst_n, .sck, .cs_n, .si, .wp_n, .hold_n,
    .so, .so_oe, .busy, .standby);
`default_nettype wire

// ===== verif/seep_master.sv
`timescale 1ns/1ns
`default_nettype none
module seep_master (
    // serial lines
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    initial begin
        sck  = 1'b0;
        cs_n = 1'b0; // powered up selected, giving the first low
        si   = 1'b0;
    end
    // sck runs only inside a frame; si is flipped after so it never looks held
    task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx   = '0;
        cs_n = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            #6 sck = 1'b1;
            rx = {rx[30:0], so};
            #6 sck = 1'b0;
        end
        #20;
        cs_n = 1'b1;
        si   = ~si;
        #600;
    endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
    import seep_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        wp_n;
    logic        hold_n;
    logic        sck;
    logic        cs_n;
    logic        si;
    logic        so;
    logic        so_oe;
    logic        busy;
    logic        standby;
    logic [31:0] rx;
    int          err_total;
    int          num_checks;
    seep_core dut (.clk, .rst_n, .sck, .cs_n, .si, .wp_n, .hold_n, .so, .so_oe, .busy,
        .standby);
    seep_master m (.sck, .cs_n, .si, .so);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // value taken at the call; the compare waits for the next falling clk edge
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        @(negedge clk);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        m.frame(8, {24'h0, op}, rx);
    endtask
    task automatic rdsr();
        m.frame(16, {16'h0, SEEP_OP_RDSR, 8'h00}, rx);
    endtask
    task automatic t_select();
        check(standby, 1'b0);
        cmd(SEEP_OP_WRDI);
        check(standby, 1'b1);
        check(so_oe, 1'b0);
        @(posedge clk) hold_n <= 1'b0;
        check(so_oe, 1'b0);
        @(posedge clk) hold_n <= 1'b1;
    endtask
    task automatic t_wel();
        cmd(SEEP_OP_WREN);
        rdsr();
        check({rx[SEEP_SR_WEL], rx[SEEP_SR_WIP]}, 2'b10);
        cmd(SEEP_OP_WRDI);
        rdsr();
        check(rx[SEEP_SR_WEL], 1'b0);
    endtask
    task automatic t_wp();
        cmd(SEEP_OP_WREN);
        @(posedge clk) wp_n <= 1'b0;
        repeat (6) @(posedge clk);
        rdsr();
        check(rx[SEEP_SR_WEL], 1'b0);
        cmd(SEEP_OP_WREN);
        m.frame(24, {8'h0, SEEP_OP_WRITE, 8'h25, 8'h3c}, rx);
        check(busy, 1'b0);
        @(posedge clk) wp_n <= 1'b1;
    endtask
    task automatic t_abort();
        cmd(SEEP_OP_WREN);
        m.frame(20, {12'h0, SEEP_OP_WRITE, 8'h25, 4'h5}, rx);
        check(busy, 1'b0);
        rdsr();
        check({rx[SEEP_SR_WEL], rx[SEEP_SR_WIP]}, 2'b10);
        cmd(SEEP_OP_WRDI);
    endtask
    task automatic t_write();
        cmd(SEEP_OP_WREN);
        m.frame(24, {8'h0, SEEP_OP_WRITE, 8'h25, 8'ha5}, rx);
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
        check(busy, 1'b1);
        @(posedge clk) wp_n <= 1'b0;
        repeat (8) @(posedge clk);
        check(standby, 1'b0);
        rdsr();
        check(rx[SEEP_SR_WIP], 1'b1);
        for (int i = 0; i < SEEP_TWC_CYC + 10 && busy !== 1'b0; i++) @(posedge clk);
        check(busy, 1'b0);
        @(posedge clk) wp_n <= 1'b1;
        repeat (8) @(posedge clk);
        check(standby, 1'b1);
        rdsr();
        check({rx[SEEP_SR_WEL], rx[SEEP_SR_WIP]}, 2'b00);
        m.frame(24, {8'h0, SEEP_OP_READ, 8'h25, 8'h00}, rx);
        check(rx[7:0], 8'ha5);
    endtask
    initial begin
        rst_n      = 1'b0;
        wp_n       = 1'b1;
        hold_n     = 1'b1;
        err_total  = 0;
        num_checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_select();
        t_wel();
        t_wp();
        t_abort();
        t_write();
        complete_run();
    end
    // one full internal write dominates the run; this leaves ample margin
    initial begin
        #8000000;
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
